// ---- dv/fcs_flash_model.sv ----
`default_nettype none
module fcs_flash_model
#(
	parameter logic [7:0] MAKER_ID = 8'h3c, // arbitrary value
	parameter logic [7:0] PART_ID  = 8'hc5, // arbitrary value
	parameter int         LOAD_CYC = 100,
	parameter int         BUSY_CYC = 300
)
(
	input  wire logic        mclk,
	input  wire logic        sel_n,
	input  wire logic        gate_n,
	input  wire logic        strobe_n,
	input  wire logic [18:0] addr,
	input  wire logic [7:0]  din,
	output wire logic [7:0]  dq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  mem [int];
	logic [7:0]  page [int];
	logic [7:0]  rv = 8'hff, ld = 8'hff, wd;
	logic [18:0] wa;
	logic [2:0]  step = 3'h0;
	logic [1:0]  lk = 2'h0;
	logic        prot = 1'b1, busy = 1'b0, load = 1'b0, tog = 1'b0, w_q = 1'b0, g_q = 1'b1;
	logic        id = 1'b0; // power-up lands in normal reads
	int          cnt = 0;
	// a released bus shows the inverse, so a stale byte never passes
	assign dq = (!sel_n && !gate_n && strobe_n) ? rv : ~rv;

	task automatic take(input logic [18:0] a, input logic [7:0] d);
		logic [14:0] c;
		c = a[14:0];
		if (step == 3'h6)
		begin
			lk = lk | {a == 19'h7ffff && d == 8'hff, a == 19'h00000 && d == 8'h00};
			step = 3'h0;
		end
		else if (step inside {3'h0, 3'h3} && c == 15'h5555 && d == 8'haa)
			step++;
		else if (step inside {3'h1, 3'h4} && c == 15'h2aaa && d == 8'h55)
			step++;
		else if (step inside {3'h2, 3'h5} && c == 15'h5555)
		begin
			case ({step[0], d})
				9'h090, 9'h190: id = 1'b1;
				9'h0f0: id = 1'b0;
				9'h0a0: prot = 1'b1;
				9'h120: prot = 1'b0;
				9'h110: busy = (lk == 2'h0);
				default: ;
			endcase
			if (busy)
			begin
				mem.delete();
				ld = 8'hff;
				cnt = 0;
			end
			step = (d == 8'h80 && !step[0]) ? 3'h3 : (d == 8'h40 && step[0]) ? 3'h6 : 3'h0;
		end
		else
		begin
			step = 3'h0;
			page[a] = d;
			ld = d;
			load = 1'b1;
			cnt = 0;
		end
	endtask

	always @(posedge mclk)
	begin
		if (!strobe_n && !sel_n && gate_n)
		begin
			wa = addr;
			wd = din;
		end
		else if (w_q && !busy)
			take(wa, wd);
		w_q = !strobe_n && !sel_n && gate_n;
		if (!gate_n && g_q && !sel_n)
			tog = ~tog;
		g_q = gate_n;
		cnt++;
		if (load && cnt >= LOAD_CYC)
		begin
			foreach (page[i])
				mem[i] = page[i];
			page.delete();
			{load, busy} = 2'b01;
			cnt = 0;
		end
		if (busy && cnt >= BUSY_CYC)
			busy = 1'b0;
		if (busy || load)
			rv <= {~ld[7], tog, ld[5:0]};
		else if (id && addr inside {19'h00000, 19'h00001})
			rv <= addr[0] ? PART_ID : MAKER_ID;
		else if (id && addr inside {19'h00002, 19'h7fff2})
			rv <= {7'h7f, lk[addr[18]]};
		else
			rv <= mem.exists(addr) ? mem[addr] : 8'hff;
	end
endmodule // fcs_flash_model
`default_nettype wire

// ---- dv/fcs_host_assertions.sv ----
`default_nettype none
module fcs_host_assertions
#(
	parameter ID_PAUSE_CYC = 20
)
(
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        sel_n,
	input wire logic        gate_n,
	input wire logic        strobe_n,
	input wire logic [18:0] addr_pin,
	input wire logic [7:0]  dq_out,
	input wire logic        dq_oe_n,
	input wire logic        id_qualifier_hv,
	input wire logic        rd_valid,
	input wire logic        wr_done
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic [31:0] pause_q;
	// loaded at the strobe fall, so a little looser than the real pause
	always @(posedge mclk or negedge rst_n)
		if (!rst_n)
			pause_q <= '0;
		else if ($fell(strobe_n) && dq_out == 8'h90 && addr_pin[14:0] == 15'h5555)
			pause_q <= ID_PAUSE_CYC;
		else if (pause_q != '0)
			pause_q <= pause_q - 32'h1;
	AST_RW: assert property (gate_n || strobe_n) else $error("overlap");
	AST_WR: assert property (!strobe_n |-> !sel_n && !dq_oe_n) else $error("bad write");
	AST_RD: assert property (!gate_n |-> !sel_n && dq_oe_n) else $error("bad read");
	AST_HOLD: assert property (
		!strobe_n && !$past(strobe_n) |-> $stable({addr_pin, dq_out}))
		else $error("moved");
	AST_WIDTH: assert property ($fell(strobe_n) |=> !strobe_n [*8]) else $error("short");
	AST_HV: assert property (!id_qualifier_hv) else $error("hv");
	AST_UNLOCK: assert property (
		$fell(strobe_n) && dq_out == 8'haa && addr_pin[14:0] == 15'h5555
		|-> ##[12:40] ($fell(strobe_n) && dq_out == 8'h55 && addr_pin[14:0] == 15'h2aaa))
		else $error("no unlock");
	AST_PAUSE: assert property (!gate_n |-> pause_q == '0) else $error("early read");
	AST_C_RD: cover property (rd_valid);
	AST_C_WR: cover property (wr_done);
	AST_C_ID: cover property ($fell(strobe_n) && dq_out == 8'h90);
endmodule // fcs_host_assertions

bind fcs_host fcs_host_assertions #(.ID_PAUSE_CYC(ID_PAUSE_CYC)) u_chk
(
	.mclk(mclk), .rst_n(rst_n), .sel_n(sel_n), .gate_n(gate_n), .strobe_n(strobe_n),
	.addr_pin(addr_pin), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .id_qualifier_hv(id_qualifier_hv),
	.rd_valid(rd_valid), .wr_done(wr_done)
);
`default_nettype wire

// ---- dv/tb_fcs_host.sv ----
`default_nettype none
`include "fcs_defs.vh"
module tb_fcs_host;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] MAKER = 8'h3c; // arbitrary value
	localparam logic [7:0] PART  = 8'hc5; // arbitrary value
	logic        mclk = 1'b0, rst_n = 1'b0, op_valid = 1'b0, op_last = 1'b0;
	logic [2:0]  op_code = 3'h0;
	logic [18:0] op_addr = '0, addr_pin;
	logic [7:0]  op_data = '0, rd_data, dq_out, fl_dq, got;
	logic        op_ready, rd_valid, wr_done, poll_timeout, sel_n, gate_n, strobe_n, dq_oe_n, hv;
	wire  logic [7:0] bus;
	int          err_count = 0, n_compared = 0;

	assign bus = dq_oe_n ? fl_dq : dq_out;

	initial
		forever #4 mclk = ~mclk;

	fcs_host #(.ID_PAUSE_CYC(20), .LOCK_PAUSE_CYC(20)) dut
	(
		.mclk(mclk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code), .op_addr(op_addr),
		.op_data(op_data), .op_last(op_last), .op_lock_last(op_last), .op_ready(op_ready),
		.rd_valid(rd_valid), .rd_data(rd_data), .wr_done(wr_done), .poll_timeout(poll_timeout),
		.dq_in(bus), .sel_n(sel_n), .gate_n(gate_n), .strobe_n(strobe_n), .addr_pin(addr_pin),
		.dq_out(dq_out), .dq_oe_n(dq_oe_n), .id_qualifier_hv(hv)
	);

	fcs_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) fl
	(
		.mclk(mclk), .sel_n(sel_n), .gate_n(gate_n), .strobe_n(strobe_n), .addr(addr_pin),
		.din(bus), .dq(fl_dq)
	);

	task automatic chk(input string w, input logic [7:0] e, input logic [7:0] s);
		n_compared++;
		if (s !== e)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", w, e, s);
		end
	endtask

	task automatic run(input logic [2:0] c, input logic [18:0] a, input logic [7:0] d,
		input logic l);
		int n;
		n = 0;
		{op_valid, op_code, op_addr, op_data, op_last} = {1'b1, c, a, d, l};
		while (op_ready !== 1'b1 && n < 99)
		begin
			@(posedge mclk) #1;
			n++;
		end
		@(posedge mclk) #1;
		op_valid = 1'b0;
		while (rd_valid !== 1'b1 && wr_done !== 1'b1 && n < 30000)
		begin
			@(posedge mclk) #1;
			n++;
		end
		got = rd_data;
		chk("handshake", 8'h00, {7'h0, n >= 30000});
	endtask

	task automatic rd(input logic [18:0] a, input logic [7:0] e, input string w);
		run(`FCS_OP_READ, a, 8'h00, 1'b0);
		chk(w, e, got);
	endtask

	task automatic t_id;
		run(`FCS_OP_ID_ENTER, '0, '0, 1'b0);
		rd(19'h00000, MAKER, "maker");
		rd(19'h00001, PART, "part");
		rd(19'h00002, 8'hfe, "lock lo");
		rd(19'h7fff2, 8'hfe, "lock hi");
		run(`FCS_OP_ID_EXIT, '0, '0, 1'b0);
		rd(19'h00000, 8'hff, "array");
		$display("test id finished");
	endtask

	task automatic t_page;
		run(`FCS_OP_UNPROTECT, '0, '0, 1'b0);
		chk("unprot", 8'h00, {7'h0, fl.prot});
		run(`FCS_OP_WRITE, 19'h00100, 8'h3c, 1'b0);
		run(`FCS_OP_WRITE, 19'h001ff, 8'ha5, 1'b1);
		chk("busy", 8'h00, {7'h0, fl.busy || fl.load});
		chk("timeout", 8'h00, {7'h0, poll_timeout});
		rd(19'h00100, 8'h3c, "byte0");
		rd(19'h001ff, 8'ha5, "byte1");
		$display("test page finished");
	endtask

	task automatic t_erase;
		run(`FCS_OP_PROTECT, 19'h00200, 8'h77, 1'b1);
		chk("prot", 8'h01, {7'h0, fl.prot});
		rd(19'h00200, 8'h77, "prot byte");
		run(`FCS_OP_ERASE, '0, '0, 1'b0);
		chk("erase busy", 8'h00, {7'h0, fl.busy});
		rd(19'h00200, 8'hff, "erased");
		$display("test erase finished");
	endtask

	task automatic t_lock;
		run(`FCS_OP_LOCK, '0, '0, 1'b0);
		run(`FCS_OP_ID_ENTER, '0, '0, 1'b0);
		rd(19'h00002, 8'hff, "locked lo");
		rd(19'h7fff2, 8'hfe, "open hi");
		run(`FCS_OP_ID_EXIT, '0, '0, 1'b0);
		// op_last also feeds op_lock_last, so this one locks the last block
		run(`FCS_OP_LOCK, '0, '0, 1'b1);
		run(`FCS_OP_ID_ENTER, '0, '0, 1'b0);
		rd(19'h7fff2, 8'hff, "locked hi");
		rd(19'h00002, 8'hff, "still lo");
		run(`FCS_OP_ID_EXIT, '0, '0, 1'b0);
		run(`FCS_OP_PROTECT, 19'h40300, 8'h5a, 1'b1);
		run(`FCS_OP_ERASE, '0, '0, 1'b0);
		rd(19'h40300, 8'h5a, "kept");
		$display("test lock finished");
	endtask

	task automatic final_report;
		$display("compared %0d mismatched %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		repeat (3) @(posedge mclk);
		#1 rst_n = 1'b1;
		repeat (2) @(posedge mclk) #1;
		t_id;
		t_page;
		t_erase;
		t_lock;
		final_report;
	end

	initial
	begin
		// all tests need well under 10k cycles; stop at 50k to stay inside budget
		#400000;
		err_count++;
		final_report;
	end
endmodule // tb_fcs_host
`default_nettype wire

// ---- hw/fcs_bus_cycle.v ----
`default_nettype none
`include "fcs_defs.vh"

// one host bus cycle: a strobed write or a read with gate low
module fcs_bus_cycle
(
	input  wire        mclk,
	input  wire        rst_n,
	input  wire        start,
	input  wire        is_write,
	input  wire [18:0] addr,
	input  wire [7:0]  wdata,
	input  wire [7:0]  dq_in,
	output reg         done,
	output reg  [7:0]  rdata,
	output reg         sel_n,
	output reg         gate_n,
	output reg         strobe_n,
	output reg  [18:0] addr_out,
	output reg  [7:0]  dq_out,
	output reg         dq_oe_n
);
	localparam [1:0] S_IDLE  = 2'b01;
	localparam [1:0] S_PULSE = 2'b10;
	localparam integer PULSE_INT = `FCS_STROBE_CYC;
	// trimmed on purpose: the strobe count fits in seven bits
	localparam [6:0] PULSE_CYC = PULSE_INT[6:0];

	reg [1:0] state_q;
	reg [6:0] cnt_q;
	reg       wr_q;

	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q  <= S_IDLE;
			cnt_q    <= 7'h00;
			wr_q     <= 1'b0;
			done     <= 1'b0;
			rdata    <= 8'h00;
			sel_n    <= 1'b1;
			gate_n   <= 1'b1;
			strobe_n <= 1'b1;
			addr_out <= 19'h00000;
			dq_out   <= 8'h00;
			dq_oe_n  <= 1'b1;
		end
		else
		begin
			done <= 1'b0;
			case (state_q)
			S_IDLE:
			begin
				if (start)
				begin
					addr_out <= addr;
					wr_q     <= is_write;
					cnt_q    <= PULSE_CYC;
					sel_n    <= 1'b0;
					if (is_write)
					begin
						// gate held high during writes or the strobe is blocked
						gate_n   <= 1'b1;
						strobe_n <= 1'b0;
						dq_out   <= wdata;
						dq_oe_n  <= 1'b0;
					end
					else
					begin
						gate_n   <= 1'b0;
						strobe_n <= 1'b1;
						dq_oe_n  <= 1'b1;
					end
					state_q <= S_PULSE;
				end
			end
			S_PULSE:
			begin
				if (cnt_q == 7'h00)
				begin
					// data is taken by the device on the strobe's rising edge
					if (!wr_q)
						rdata <= dq_in;
					sel_n    <= 1'b1;
					gate_n   <= 1'b1;
					strobe_n <= 1'b1;
					dq_oe_n  <= 1'b1;
					done     <= 1'b1;
					state_q  <= S_IDLE;
				end
				else
					cnt_q <= cnt_q - 7'h01;
			end
			default:
				state_q <= S_IDLE;
			endcase
		end
	end
endmodule // fcs_bus_cycle

`default_nettype wire

// ---- hw/fcs_defs.vh ----
`ifndef FCS_DEFS_VH
`define FCS_DEFS_VH

// command cycle addresses and data
`define FCS_ADDR_UNLOCK1     19'h05555
`define FCS_ADDR_UNLOCK2     19'h02aaa
`define FCS_DATA_UNLOCK1     8'haa
`define FCS_DATA_UNLOCK2     8'h55
`define FCS_CMD_PROTECT      8'ha0
`define FCS_CMD_SETUP        8'h80
`define FCS_CMD_UNPROTECT    8'h20
`define FCS_CMD_ERASE        8'h10
`define FCS_CMD_LOCK         8'h40
`define FCS_CMD_ID_ENTER     8'h90
`define FCS_CMD_ID_EXIT      8'hf0
`define FCS_ADDR_LOCK_FIRST  19'h00000
`define FCS_DATA_LOCK_FIRST  8'h00
`define FCS_ADDR_LOCK_LAST   19'h7ffff
`define FCS_DATA_LOCK_LAST   8'hff
`define FCS_ADDR_ID_MAKER    19'h00000
`define FCS_ADDR_ID_PART     19'h00001
`define FCS_ADDR_LOCK_DET_LO 19'h00002
`define FCS_ADDR_LOCK_DET_HI 19'h7fff2

// operation codes on the user port
`define FCS_OP_READ          3'h0
`define FCS_OP_WRITE         3'h1
`define FCS_OP_PROTECT       3'h2
`define FCS_OP_UNPROTECT     3'h3
`define FCS_OP_ERASE         3'h4
`define FCS_OP_LOCK          3'h5
`define FCS_OP_ID_ENTER      3'h6
`define FCS_OP_ID_EXIT       3'h7

// timing, clock 125 mhz
`define FCS_CLK_MHZ          125
`define FCS_STROBE_NS        80
`define FCS_STROBE_CYC       ((`FCS_STROBE_NS * `FCS_CLK_MHZ + 999) / 1000)
`define FCS_ID_PAUSE_US      10
`define FCS_ID_PAUSE_CYC     (`FCS_ID_PAUSE_US * `FCS_CLK_MHZ)
`define FCS_LOCK_PAUSE_MS    10
`define FCS_LOCK_PAUSE_CYC   (`FCS_LOCK_PAUSE_MS * 1000 * `FCS_CLK_MHZ)
`define FCS_LOAD_WINDOW_US   200
`define FCS_LOAD_WINDOW_CYC  (`FCS_LOAD_WINDOW_US * `FCS_CLK_MHZ)
`define FCS_POLL_LIMIT       24'hffffff

`endif

// ---- hw/fcs_host.v ----
`default_nettype none
`include "fcs_defs.vh"

// Notes on behaviour
// - id entry: aa@5555, 55@2aaa, 90@5555, then wait 10 us
// - id exit: aa@5555, 55@2aaa, f0@5555 returns to array reads
// - protected write: aa@5555, 55@2aaa, a0@5555, then page data
// - unprotect: six bytes ending 20@5555
// - chip erase: six bytes ending 10@5555
// - lock: six bytes ending 40@5555, then 00@0 or ff@7ffff, wait 10 ms
// - page bytes within 200 us of each other, same address 18..8; the host checks neither, it sends each byte when op_valid brings it
module fcs_host
#(
	parameter ID_PAUSE_CYC   = `FCS_ID_PAUSE_CYC,
	parameter LOCK_PAUSE_CYC = `FCS_LOCK_PAUSE_CYC
)
(
	input  wire        mclk,
	input  wire        rst_n,
	input  wire        op_valid,
	input  wire [2:0]  op_code,
	input  wire [18:0] op_addr,
	input  wire [7:0]  op_data,
	input  wire        op_last,
	input  wire        op_lock_last,
	output reg         op_ready,
	output reg         rd_valid,
	output reg  [7:0]  rd_data,
	output reg         wr_done,
	output reg         poll_timeout,
	input  wire [7:0]  dq_in,
	output reg         sel_n,
	output reg         gate_n,
	output reg         strobe_n,
	output reg  [18:0] addr_pin,
	output reg  [7:0]  dq_out,
	output reg         dq_oe_n,
	output reg         id_qualifier_hv
);
	localparam [4:0] S_IDLE = 5'b00001;
	localparam [4:0] S_SEQ  = 5'b00010;
	localparam [4:0] S_WAIT = 5'b00100;
	localparam [4:0] S_POLL = 5'b01000;
	localparam [4:0] S_DONE = 5'b10000;
	localparam [23:0] ID_PAUSE   = ID_PAUSE_CYC[23:0];
	localparam [23:0] LOCK_PAUSE = LOCK_PAUSE_CYC[23:0];

	reg  [4:0]  state_q;
	reg  [2:0]  op_q;
	reg  [2:0]  step_q;
	reg  [18:0] addr_q;
	reg  [7:0]  data_q;
	reg         last_q;
	reg         lock_last_q;
	reg  [23:0] wait_q;
	reg         prev_q;
	reg         poll_rd_q;
	reg         bc_start;
	reg         bc_write;
	reg  [18:0] bc_addr;
	reg  [7:0]  bc_wdata;
	reg  [2:0]  seq_len;
	wire        bc_done;
	wire [7:0]  bc_rdata;
	wire        bc_sel_n;
	wire        bc_gate_n;
	wire        bc_strobe_n;
	wire [18:0] bc_addr_out;
	wire [7:0]  bc_dq_out;
	wire        bc_dq_oe_n;

	fcs_bus_cycle u_cycle
	(
		.mclk     (mclk),
		.rst_n    (rst_n),
		.start    (bc_start),
		.is_write (bc_write),
		.addr     (bc_addr),
		.wdata    (bc_wdata),
		.dq_in    (dq_in),
		.done     (bc_done),
		.rdata    (bc_rdata),
		.sel_n    (bc_sel_n),
		.gate_n   (bc_gate_n),
		.strobe_n (bc_strobe_n),
		.addr_out (bc_addr_out),
		.dq_out   (bc_dq_out),
		.dq_oe_n  (bc_dq_oe_n)
	);

	// command steps; upper address bits stay zero on the 5555 and 2aaa cycles since they are ignored
	always @*
	begin
		bc_addr  = `FCS_ADDR_UNLOCK1;
		bc_wdata = `FCS_DATA_UNLOCK1;
		case (op_q)
		`FCS_OP_PROTECT:   seq_len = 3'd4;
		`FCS_OP_UNPROTECT: seq_len = 3'd6;
		`FCS_OP_ERASE:     seq_len = 3'd6;
		`FCS_OP_LOCK:      seq_len = 3'd7;
		`FCS_OP_ID_ENTER:  seq_len = 3'd3;
		`FCS_OP_ID_EXIT:   seq_len = 3'd3;
		default:           seq_len = 3'd1;
		endcase
		if (op_q == `FCS_OP_READ || op_q == `FCS_OP_WRITE)
		begin
			bc_addr  = addr_q;
			bc_wdata = data_q;
		end
		else if (step_q == 3'd1 || step_q == 3'd4)
		begin
			bc_addr  = `FCS_ADDR_UNLOCK2;
			bc_wdata = `FCS_DATA_UNLOCK2;
		end
		else if (step_q == 3'd2)
		begin
			case (op_q)
			`FCS_OP_PROTECT:  bc_wdata = `FCS_CMD_PROTECT;
			`FCS_OP_ID_ENTER: bc_wdata = `FCS_CMD_ID_ENTER;
			`FCS_OP_ID_EXIT:  bc_wdata = `FCS_CMD_ID_EXIT;
			default:          bc_wdata = `FCS_CMD_SETUP;
			endcase
		end
		else if (step_q == 3'd3 && op_q == `FCS_OP_PROTECT)
		begin
			// first page byte follows the protect prefix
			bc_addr  = addr_q;
			bc_wdata = data_q;
		end
		else if (step_q == 3'd5)
		begin
			case (op_q)
			`FCS_OP_UNPROTECT: bc_wdata = `FCS_CMD_UNPROTECT;
			`FCS_OP_ERASE:     bc_wdata = `FCS_CMD_ERASE;
			default:           bc_wdata = `FCS_CMD_LOCK;
			endcase
		end
		else if (step_q == 3'd6)
		begin
			bc_addr  = lock_last_q ? `FCS_ADDR_LOCK_LAST : `FCS_ADDR_LOCK_FIRST;
			bc_wdata = lock_last_q ? `FCS_DATA_LOCK_LAST : `FCS_DATA_LOCK_FIRST;
		end
		bc_write = (op_q != `FCS_OP_READ) || (state_q == S_POLL);
		if (state_q == S_POLL)
		begin
			bc_addr  = addr_q;
			bc_write = 1'b0;
		end
	end

	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q         <= S_IDLE;
			op_q            <= `FCS_OP_READ;
			step_q          <= 3'd0;
			addr_q          <= 19'h00000;
			data_q          <= 8'h00;
			last_q          <= 1'b0;
			lock_last_q     <= 1'b0;
			wait_q          <= 24'h000000;
			prev_q          <= 1'b0;
			poll_rd_q       <= 1'b0;
			bc_start        <= 1'b0;
			op_ready        <= 1'b0;
			rd_valid        <= 1'b0;
			rd_data         <= 8'h00;
			wr_done         <= 1'b0;
			poll_timeout    <= 1'b0;
			sel_n           <= 1'b1;
			gate_n          <= 1'b1;
			strobe_n        <= 1'b1;
			addr_pin        <= 19'h00000;
			dq_out          <= 8'h00;
			dq_oe_n         <= 1'b1;
			id_qualifier_hv <= 1'b0;
		end
		else
		begin
			bc_start <= 1'b0;
			rd_valid <= 1'b0;
			wr_done  <= 1'b0;
			op_ready <= 1'b0;
			// pins re-registered so every top output is a flip-flop
			sel_n    <= bc_sel_n;
			gate_n   <= bc_gate_n;
			strobe_n <= bc_strobe_n;
			addr_pin <= bc_addr_out;
			dq_out   <= bc_dq_out;
			dq_oe_n  <= bc_dq_oe_n;
			case (state_q)
			S_IDLE:
			begin
				op_ready <= 1'b1;
				if (op_valid && op_ready)
				begin
					op_ready    <= 1'b0;
					op_q        <= op_code;
					addr_q      <= op_addr;
					data_q      <= op_data;
					last_q      <= op_last;
					lock_last_q <= op_lock_last;
					step_q      <= 3'd0;
					bc_start    <= 1'b1;
					state_q     <= S_SEQ;
				end
			end
			S_SEQ:
			begin
				if (bc_done)
				begin
					if (step_q == seq_len - 3'd1)
					begin
						if (op_q == `FCS_OP_READ)
						begin
							rd_data  <= bc_rdata;
							rd_valid <= 1'b1;
							state_q  <= S_IDLE;
						end
						else if (op_q == `FCS_OP_ID_ENTER || op_q == `FCS_OP_ID_EXIT)
						begin
							wait_q  <= ID_PAUSE;
							state_q <= S_WAIT;
						end
						else if (op_q == `FCS_OP_LOCK)
						begin
							wait_q  <= LOCK_PAUSE;
							state_q <= S_WAIT;
						end
						else if ((op_q == `FCS_OP_WRITE || op_q == `FCS_OP_PROTECT)
							&& !last_q)
							state_q <= S_DONE; // page still open, next byte soon
						else
						begin
							// erase, unprotect or final page byte: poll until done
							poll_rd_q <= 1'b0;
							wait_q    <= `FCS_POLL_LIMIT;
							bc_start  <= 1'b1;
							state_q   <= S_POLL;
						end
					end
					else
					begin
						step_q   <= step_q + 3'd1;
						bc_start <= 1'b1;
					end
				end
			end
			S_WAIT:
			begin
				if (wait_q == 24'h000000)
					state_q <= S_DONE;
				else
					wait_q <= wait_q - 24'h000001;
			end
			S_POLL:
			begin
				if (wait_q != 24'h000000)
					wait_q <= wait_q - 24'h000001;
				if (bc_done)
				begin
					prev_q    <= bc_rdata[6];
					poll_rd_q <= 1'b1;
					// done when bit 6 stops toggling and, except for erase or unprotect, bit 7 matches
					if (poll_rd_q && (bc_rdata[6] == prev_q)
						&& (op_q == `FCS_OP_ERASE || op_q == `FCS_OP_UNPROTECT
						|| bc_rdata[7] == data_q[7]))
						state_q <= S_DONE;
					else if (wait_q == 24'h000000)
					begin
						poll_timeout <= 1'b1;
						state_q      <= S_DONE;
					end
					else
						bc_start <= 1'b1;
				end
			end
			S_DONE:
			begin
				wr_done <= 1'b1;
				state_q <= S_IDLE;
			end
			default:
				state_q <= S_IDLE;
			endcase
		end
	end
endmodule // fcs_host

`default_nettype wire
